// ### verilog/cic_regs.sv
// CPU interrupt controller: registers, level arbitration and executing flags
`timescale 1ns/100ps
module cic_regs import cic_pkg::*; (
	input wire logic clk_i,                // 250 MHz clock
	input wire logic rst_i,                // Synchronous reset, high
	input wire logic [7:0] wb_adr_i,       // Byte address
	input wire logic [31:0] wb_dat_i,      // Write data
	output logic [31:0] wb_dat_o,          // Read data
	input wire logic wb_we_i,              // Write
	input wire logic [3:0] wb_sel_i,       // Byte lanes
	input wire logic wb_cyc_i,             // Cycle
	input wire logic wb_stb_i,             // Strobe
	output logic wb_ack_o,                 // Acknowledge
	input wire logic [CIC_NV-1:0] irq_req_i, // Requests by vector
	input wire logic gie_i,                // Global interrupt enable
	input wire logic ccp_key_i,            // I/O register key written, pulse
	input wire logic instr_done_i,         // Instruction retired, pulse
	input wire logic [15:0] app_start_i,   // Application start from boot end fuse
	output logic irq_take_o,               // Vector offered to the core
	output logic [7:0] irq_vec_o,          // Offered vector number
	output logic [15:0] irq_addr_o,        // Offered vector address
	output logic [1:0] irq_lvl_o,          // Offered level
	input wire logic irq_ack_i,            // Core enters handler, pulse
	input wire logic return_from_interrupt_i                // Return from interrupt, pulse
);

	// ************************************************************
	// State
	// ************************************************************
	logic vsel_q, vsel_d;                  // vector_select
	logic cvt_q, cvt_d;                    // compact_table_enable
	logic rr_q, rr_d;                      // round_robin_enable
	logic [7:0] last_q, last_d;            // last_ack_vector_field
	logic [7:0] l1v_q, l1v_d;              // high_level_vector_field
	logic nmi_ex_q, nmi_ex_d;              // nonmaskable_executing
	logic l1_ex_q, l1_ex_d;                // high_level_executing
	logic l0_ex_q, l0_ex_d;                // normal_level_executing
	logic [2:0] win_q, win_d;              // Protection window left
	cic_state_t state_q, state_d;          // Offer state
	logic [7:0] vec_q, vec_d;              // Offered vector
	cic_lvl_t lvl_q, lvl_d;                // Offered level
	logic [15:0] addr_q, addr_d;           // Offered address
	logic ack_q, ack_d;                    // Bus acknowledge
	logic [31:0] rdat_q, rdat_d;           // Bus read data

	// ************************************************************
	// Request classification
	// ************************************************************
	logic [CIC_NV-1:0] l1_line;            // One-hot of level 1 line
	logic [CIC_NV-1:0] nmi_req;            // Non-maskable requests
	logic [CIC_NV-1:0] l0_req;             // Normal requests
	logic nmi_v, l0_v;                     // Arbiter valids
	logic [7:0] nmi_idx, l0_idx;           // Arbiter picks
	logic nmi_go, l1_go, l0_go;            // Level may be taken now
	logic any_go;                          // Something can be offered
	cic_lvl_t best_lvl;                    // Highest level ready
	logic [7:0] best_vec;                  // Its vector
	logic [7:0] best_idx;                  // Its table slot
	logic win_open;                        // Protected bits writable

	// Split requests into levels
	always_comb begin
		l1_line = '0;
		if (l1v_q != CIC_L1_NONE && l1v_q < 8'(CIC_NV)) begin
			l1_line[l1v_q[4:0]] = 1'b1;
		end
		nmi_req = irq_req_i & CIC_NMI_MASK;
		l0_req = irq_req_i & ~CIC_NMI_MASK & ~l1_line;
	end

	// Several non-maskable lines: always lowest address first
	cic_arb u_nmi_arb (
		.req_i(nmi_req),
		.rr_en_i(1'b0),
		.last_i(8'h00),
		.valid_o(nmi_v),
		.idx_o(nmi_idx)
	);

	// Normal level arbiter
	cic_arb u_l0_arb (
		.req_i(l0_req),
		.rr_en_i(rr_q),
		.last_i(last_q),
		.valid_o(l0_v),
		.idx_o(l0_idx)
	);

	// Which level may start; non-maskable ignores the global enable
	always_comb begin
		nmi_go = nmi_v && !nmi_ex_q;
		l1_go = |(irq_req_i & l1_line & ~CIC_NMI_MASK) && gie_i && !nmi_ex_q && !l1_ex_q;
		l0_go = l0_v && gie_i && !nmi_ex_q && !l1_ex_q && !l0_ex_q;
		any_go = nmi_go || l1_go || l0_go;
		if (nmi_go) begin
			best_lvl = CIC_LVLN;
			best_vec = nmi_idx;
		end else if (l1_go) begin
			best_lvl = CIC_LVL1;
			best_vec = l1v_q;
		end else begin
			best_lvl = CIC_LVL0;
			best_vec = l0_idx;
		end
		if (cvt_q) begin
			case (best_lvl)
				CIC_LVLN: best_idx = CIC_CVT_NMI;
				CIC_LVL1: best_idx = CIC_CVT_L1;
				default: best_idx = CIC_CVT_L0;
			endcase
		end else begin
			best_idx = best_vec;
		end
	end

	// ************************************************************
	// Offer to the core
	// ************************************************************

	// Hold the offer stable; drop it if the request goes or is outranked
	always_comb begin
		state_d = state_q;
		vec_d = vec_q;
		lvl_d = lvl_q;
		addr_d = addr_q;
		case (state_q)
			CIC_IDLE: begin
				if (any_go) begin
					state_d = CIC_OFFER;
					vec_d = best_vec;
					lvl_d = best_lvl;
					addr_d = (vsel_q ? CIC_BOOT_START : app_start_i) + 16'(best_idx) * CIC_VEC_WORDS;
				end
			end
			CIC_OFFER: begin
				if (irq_ack_i) begin
					state_d = CIC_IDLE;
				end else if (!any_go || best_lvl != lvl_q || best_vec != vec_q) begin
					state_d = CIC_IDLE;
				end
			end
			default: begin
				state_d = CIC_IDLE;
			end
		endcase
	end

	// Offer registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= CIC_IDLE;
			vec_q <= 8'h00;
			lvl_q <= CIC_LVL0;
			addr_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			vec_q <= vec_d;
			lvl_q <= lvl_d;
			addr_q <= addr_d;
		end
	end

	assign irq_take_o = (state_q == CIC_OFFER);
	assign irq_vec_o = vec_q;
	assign irq_addr_o = addr_q;
	assign irq_lvl_o = lvl_q;

	// ************************************************************
	// Executing flags and last vector
	// ************************************************************
	logic entry;                           // Handler entered this cycle
	logic bus_wr;                          // Write lands this cycle
	logic [5:0] bus_idx;                   // Addressed register

	assign entry = irq_take_o && irq_ack_i;
	assign bus_idx = wb_adr_i[7:2];
	assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];

	// Return clears first, then entry sets, so a set is never lost
	always_comb begin
		nmi_ex_d = nmi_ex_q;
		l1_ex_d = l1_ex_q;
		l0_ex_d = l0_ex_q;
		last_d = last_q;
		if (return_from_interrupt_i) begin
			if (nmi_ex_q) begin
				nmi_ex_d = 1'b0;
			end else if (l1_ex_q) begin
				l1_ex_d = 1'b0;
			end else begin
				l0_ex_d = 1'b0;
			end
		end
		if (bus_wr && bus_idx == CIC_IDX_LAST) begin
			last_d = wb_dat_i[7:0];
		end
		if (entry) begin
			case (lvl_q)
				CIC_LVLN: nmi_ex_d = 1'b1;
				CIC_LVL1: l1_ex_d = 1'b1;
				default: begin
					l0_ex_d = 1'b1;
					if (rr_q) begin
						last_d = vec_q;
					end
				end
			endcase
		end
	end

	// Flag registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_ex_q <= 1'b0;
			l1_ex_q <= 1'b0;
			l0_ex_q <= 1'b0;
			last_q <= CIC_RST_LAST;
		end else begin
			nmi_ex_q <= nmi_ex_d;
			l1_ex_q <= l1_ex_d;
			l0_ex_q <= l0_ex_d;
			last_q <= last_d;
		end
	end

	// ************************************************************
	// Protection window
	// ************************************************************

	// Counts retired instructions after the key; a fresh key restarts it
	always_comb begin
		win_d = win_q;
		if (ccp_key_i) begin
			win_d = CIC_CCP_INSTR;
		end else if (instr_done_i && win_q != 3'h0) begin
			win_d = win_q - 3'h1;
		end
	end

	assign win_open = (win_q != 3'h0);

	// Window register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			win_q <= 3'h0;
		end else begin
			win_q <= win_d;
		end
	end

	// ************************************************************
	// Control registers
	// ************************************************************

	// Status offset takes no write at all
	always_comb begin
		vsel_d = vsel_q;
		cvt_d = cvt_q;
		rr_d = rr_q;
		l1v_d = l1v_q;
		if (bus_wr && bus_idx == CIC_IDX_CTRL) begin
			rr_d = wb_dat_i[CIC_B_RR];
			if (win_open) begin
				vsel_d = wb_dat_i[CIC_B_VSEL];
				cvt_d = wb_dat_i[CIC_B_CVT];
			end
		end
		if (bus_wr && bus_idx == CIC_IDX_L1V) begin
			l1v_d = wb_dat_i[7:0];
		end
	end

	// Control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vsel_q <= CIC_RST_CTRL[CIC_B_VSEL];
			cvt_q <= CIC_RST_CTRL[CIC_B_CVT];
			rr_q <= CIC_RST_CTRL[CIC_B_RR];
			l1v_q <= CIC_RST_L1V;
		end else begin
			vsel_q <= vsel_d;
			cvt_q <= cvt_d;
			rr_q <= rr_d;
			l1v_q <= l1v_d;
		end
	end

	// ************************************************************
	// Wishbone slave
	// ************************************************************

	// One wait state; read data caught as ack rises, unmapped reads zero
	always_comb begin
		ack_d = wb_cyc_i && wb_stb_i && !ack_q;
		rdat_d = rdat_q;
		if (ack_d) begin
			rdat_d = 32'h0000_0000;
			case (bus_idx)
				CIC_IDX_CTRL: begin
					rdat_d[CIC_B_VSEL] = vsel_q;
					rdat_d[CIC_B_CVT] = cvt_q;
					rdat_d[CIC_B_RR] = rr_q;
				end
				CIC_IDX_STAT: begin
					rdat_d[CIC_B_NONMASKABLE_EXECUTING] = nmi_ex_q;
					rdat_d[CIC_B_L1EX] = l1_ex_q;
					rdat_d[CIC_B_L0EX] = l0_ex_q;
				end
				CIC_IDX_LAST: rdat_d[7:0] = last_q;
				CIC_IDX_L1V: rdat_d[7:0] = l1v_q;
				default: rdat_d = 32'h0000_0000;
			endcase
		end
	end

	// Bus registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

endmodule

// ### verilog/cic_pkg.sv
// Constants, register map and types of the CPU interrupt controller block
//
// Functional notes
// - Vector select, compact bit need protection window
// - Round-robin bit writable at any time
// - Vector select 0 application, 1 boot start
// - Compact bit 0 disables, 1 enables table
// - Round-robin off: lowest vector wins level 0
// - Non-maskable executing flag, cleared by return
// - Level 1 flag holds through non-maskable preemption
// - Level 0 flag holds through any preemption
// - Record last level 0 vector, lowest next
// - Reset gives fixed order, last field zero
// - Level 1 register names the one vector
// - Level 1 register zero disables level 1
// - Level 1 preempts running level 0 handler
// - Compact table: vectors 1, 2, 3
// - Nothing preempts a non-maskable handler
package cic_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int CIC_NV = 32;                  // Request lines, bit n is vector n
	localparam int CIC_DW = 8;                   // Register width

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [5:0] CIC_IDX_CTRL = 6'h00;   // interrupt_control
	localparam logic [5:0] CIC_IDX_STAT = 6'h01;   // interrupt_status
	localparam logic [5:0] CIC_IDX_LAST = 6'h02;   // level0_last_vector
	localparam logic [5:0] CIC_IDX_L1V = 6'h03;    // level1_vector_select

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CIC_B_VSEL = 6;               // vector_select
	localparam int CIC_B_CVT = 5;                // compact_table_enable
	localparam int CIC_B_RR = 0;                 // round_robin_enable
	localparam int CIC_B_NONMASKABLE_EXECUTING = 7;              // nonmaskable_executing
	localparam int CIC_B_L1EX = 1;               // high_level_executing
	localparam int CIC_B_L0EX = 0;               // normal_level_executing

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] CIC_RST_CTRL = 8'h00;
	localparam logic [7:0] CIC_RST_LAST = 8'h00;
	localparam logic [7:0] CIC_RST_L1V = 8'h00;
	localparam logic [7:0] CIC_L1_NONE = 8'h00;    // Level 1 disabled value

	// ************************************************************
	// Vectors and protection
	// ************************************************************
	localparam logic [CIC_NV-1:0] CIC_NMI_MASK = 32'h0000_0002;  // Lines that are non-maskable
	localparam logic [7:0] CIC_CVT_NMI = 8'h01;    // Compact vector of non-maskable
	localparam logic [7:0] CIC_CVT_L1 = 8'h02;     // Compact vector of level 1
	localparam logic [7:0] CIC_CVT_L0 = 8'h03;     // Compact vector shared by level 0
	localparam logic [15:0] CIC_VEC_WORDS = 16'h0002;  // Flash words per vector slot
	localparam logic [15:0] CIC_BOOT_START = 16'h0000; // Boot section start
	localparam logic [2:0] CIC_CCP_INSTR = 3'h4;   // Instructions the key window lasts

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		CIC_LVL0 = 2'h0,
		CIC_LVL1 = 2'h1,
		CIC_LVLN = 2'h2
	} cic_lvl_t;

	typedef enum logic {
		CIC_IDLE = 1'b0,                         // Nothing offered
		CIC_OFFER = 1'b1                         // Vector offered to the core
	} cic_state_t;

endpackage

// ### verilog/cic_arb.sv
// Fixed or round-robin selection of one request line
`timescale 1ns/100ps
module cic_arb import cic_pkg::*; (
	input wire logic [CIC_NV-1:0] req_i,   // Pending lines
	input wire logic rr_en_i,              // Round-robin enable
	input wire logic [7:0] last_i,         // Last granted vector
	output logic valid_o,                  // Some line pending
	output logic [7:0] idx_o               // Selected vector
);

	// ************************************************************
	// Lowest set bit
	// ************************************************************
	function automatic logic [7:0] cic_lowest(input logic [CIC_NV-1:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = CIC_NV - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 8'(i);
			end
		end
		return r;
	endfunction

	logic [CIC_NV-1:0] above; // Lines after the last granted one

	// Lines ranked above the last winner
	for (genvar g = 0; g < CIC_NV; g++) begin : g_above
		assign above[g] = (8'(g) > last_i);
	end

	// Pick: wrap past last when rotating, else lowest address
	always_comb begin
		valid_o = |req_i;
		if (rr_en_i && |(req_i & above)) begin
			idx_o = cic_lowest(req_i & above);
		end else begin
			idx_o = cic_lowest(req_i);
		end
	end

endmodule

// ### verif/cic_regs_properties.sv
// Port-level checks of the interrupt controller register block
`timescale 1ns/100ps
module cic_regs_chk import cic_pkg::*; (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic [7:0] wb_adr_i, // Address
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_we_i, // Write
	input wire logic [3:0] wb_sel_i, // Lanes
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_ack_o, // Acknowledge
	input wire logic [CIC_NV-1:0] irq_req_i, // Requests
	input wire logic gie_i, // Global enable
	input wire logic ccp_key_i, // Key pulse
	input wire logic instr_done_i, // Retire pulse
	input wire logic [15:0] app_start_i, // Application start
	input wire logic irq_take_o, // Offer
	input wire logic [7:0] irq_vec_o, // Vector
	input wire logic [15:0] irq_addr_o, // Address
	input wire logic [1:0] irq_lvl_o, // Level
	input wire logic irq_ack_i, // Entry
	input wire logic return_from_interrupt_i // Return
);
	// ****
	// Shadow of the non-maskable handler
	// ****
	logic nmi_q; // Handler running
	logic nmi_d; // Next value
	// Entry wins over a return in the same cycle
	always_comb begin
		nmi_d = return_from_interrupt_i ? 1'b0 : nmi_q;
		if (irq_take_o && irq_ack_i && irq_lvl_o == CIC_LVLN) begin
			nmi_d = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		nmi_q <= rst_i ? 1'b0 : nmi_d;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****
	// Properties
	// ****
	bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus not answered");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	rst_clear_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_take_o)
		else $error("reset not clearing");
	nmi_block_a: assert property (nmi_q |-> !irq_take_o)
		else $error("offer during nmi");
	nmi_vec_a: assert property (irq_take_o && irq_lvl_o == CIC_LVLN |-> irq_vec_o == 8'h01)
		else $error("nmi vector");
	gie_gate_a: assert property ($rose(irq_take_o) && irq_lvl_o != CIC_LVLN |-> $past(gie_i))
		else $error("maskable offer without gie");
	l1_nonzero_a: assert property (irq_take_o && irq_lvl_o == CIC_LVL1 |-> irq_vec_o != CIC_L1_NONE)
		else $error("level 1 with zero vector");
	take_drop_a: assert property (irq_take_o && irq_ack_i |=> !irq_take_o)
		else $error("offer after entry");
endmodule
bind cic_regs cic_regs_chk chk_u (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq_req_i, .gie_i, .ccp_key_i, .instr_done_i, .app_start_i,
	.irq_take_o, .irq_vec_o, .irq_addr_o, .irq_lvl_o, .irq_ack_i, .return_from_interrupt_i);

// ### verif/cic_core_model.sv
// Behavioural CPU core that enters handlers on offers
`timescale 1ns/100ps
module cic_core_model (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic take_i, // Offer from the controller
	input wire logic [3:0] wait_i, // Cycles before entry
	output logic ack_o // Entry pulse
);
	logic [3:0] cnt_q; // Cycles the offer stood
	logic [3:0] cnt_d; // Next count
	logic ack_d; // Next entry pulse
	// Enter once the wait ran out; a withdrawn offer restarts it
	always_comb begin
		cnt_d = 4'h0;
		ack_d = 1'b0;
		if (take_i && !ack_o) begin
			ack_d = (cnt_q >= wait_i);
			cnt_d = ack_d ? 4'h0 : cnt_q + 4'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		cnt_q <= rst_i ? 4'h0 : cnt_d;
		ack_o <= rst_i ? 1'b0 : ack_d;
	end
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the interrupt controller register block
`timescale 1ns/100ps
module tb_top import cic_pkg::*;;
	logic clk, rst, we, cyc, stb, gie, key, ins, return_from_interrupt, ack, take, iack, vsel, compact_table_enable, rr;
	logic [7:0] adr, vec, r;
	logic [31:0] wdat, rdat, rnd, req;
	logic [31:0] seed = 32'h9813; // Fixed seed
	logic [15:0] app, addr;
	logic [3:0] sel, cwait;
	logic [1:0] lvl;
	int fails, comparisons, i, a, b, j, k, n;
	cic_regs dut_u (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we),
		.wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .irq_req_i(req), .gie_i(gie),
		.ccp_key_i(key), .instr_done_i(ins), .app_start_i(app), .irq_take_o(take), .irq_vec_o(vec),
		.irq_addr_o(addr), .irq_lvl_o(lvl), .irq_ack_i(iack), .return_from_interrupt_i(return_from_interrupt));
	cic_core_model core_u (.clk_i(clk), .rst_i(rst), .take_i(take), .wait_i(cwait), .ack_o(iack));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Expected vector address from the shadow control bits
	function automatic logic [15:0] exp_addr(input logic [7:0] v, input cic_lvl_t l);
		logic [7:0] s;
		s = v;
		if (compact_table_enable) begin
			s = (l == CIC_LVLN) ? CIC_CVT_NMI : ((l == CIC_LVL1) ? CIC_CVT_L1 : CIC_CVT_L0);
		end
		return (vsel ? CIC_BOOT_START : app) + {8'h00, s} * CIC_VEC_WORDS;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Classic single Wishbone cycle, read data left in r
	task automatic wb(input logic [7:0] ad, input logic w, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge clk);
		adr <= ad;
		we <= w;
		wdat <= {24'h0, d};
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk);
			t++;
		end while (ack !== 1'b1 && t < 20);
		r = rdat[7:0];
		chk(32'(ack), 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// key, nr retired instructions, then the write
	task automatic setctl(input logic [7:0] v, input int nr);
		@(posedge clk);
		key <= 1'b1;
		@(posedge clk);
		key <= 1'b0;
		// Retire pulses only when asked, so ins is driven once per edge
		if (nr > 0) begin
			ins <= 1'b1;
			repeat (nr) @(posedge clk);
			ins <= 1'b0;
		end
		wb(8'h00, 1'b1, v);
		if (nr < CIC_CCP_INSTR) begin
			vsel = v[6];
			compact_table_enable = v[5];
		end
		rr = v[0];
		wb(8'h00, 1'b0, 8'h00);
		chk(32'(r), {25'h0, vsel, compact_table_enable, 4'h0, rr});
	endtask
	task automatic st(input logic [7:0] e);
		wb(8'h04, 1'b0, 8'h00);
		chk(32'(r), 32'(e));
	endtask
	task automatic ret();
		@(posedge clk);
		return_from_interrupt <= 1'b1;
		@(posedge clk);
		return_from_interrupt <= 1'b0;
	endtask
	// Wait for an offer, compare it, let the core enter
	task automatic offer(input logic [7:0] v, input cic_lvl_t l);
		int t;
		t = 0;
		rnd = xs();
		cwait <= {2'h0, rnd[1:0]};
		while (take !== 1'b1 && t < 50) begin
			t++;
			@(posedge clk);
		end
		chk(32'(take), 32'h1);
		chk(32'(vec), 32'(v));
		chk(32'(lvl), 32'(l));
		chk(32'(addr), 32'(exp_addr(v, l)));
		while (take === 1'b1 && t < 100) begin
			t++;
			@(posedge clk);
		end
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_sim();
	end
	initial begin
		{rst, we, cyc, stb, gie, key, ins, return_from_interrupt, vsel, compact_table_enable, rr} = 11'h400;
		{adr, wdat, req, app, cwait} = 92'h0;
		sel = 4'h1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// Reset values and one unmapped place
		for (i = 0; i < 5; i++) begin
			wb(8'(i * 4), 1'b0, 8'h00);
			chk(32'(r), 32'h0);
		end
		wb(8'h00, 1'b1, 8'h61);
		wb(8'h00, 1'b0, 8'h00);
		chk(32'(r), 32'h01);
		setctl(8'h61, 3);
		setctl(8'h00, 4);
		wb(8'h04, 1'b1, 8'hff);
		st(8'h00);
		$display("protection test done");
		gie <= 1'b1;
		for (i = 0; i < 4; i++) begin
			rnd = xs();
			app <= rnd[15:0];
			setctl(8'(i << 5), 0);
			k = 2 + xs() % 30;
			req[k] <= 1'b1;
			offer(8'(k), CIC_LVL0);
			req <= 32'h0;
			st(8'h01);
			ret();
			st(8'h00);
		end
		$display("placement test done");
		for (i = 0; i < 2; i++) begin
			setctl(8'(i), 0);
			a = 2 + xs() % 15;
			b = a + 1 + xs() % 14;
			req[a] <= 1'b1;
			req[b] <= 1'b1;
			offer(8'(a), CIC_LVL0);
			ret();
			offer(8'(rr ? b : a), CIC_LVL0);
			wb(8'h08, 1'b0, 8'h00);
			chk(32'(r), rr ? 32'(b) : 32'h0);
			ret();
			// Round-robin: nothing pending above the last winner b, so the order wraps to a; fixed order: a wins again
			offer(8'(a), CIC_LVL0);
			req <= 32'h0;
			ret();
		end
		$display("priority test done");
		setctl(8'h20, 0);
		k = 3 + xs() % 29;
		j = 2 + xs() % (k - 2);
		wb(8'h0c, 1'b1, 8'(k));
		gie <= 1'b0;
		req[1] <= 1'b1;
		req[j] <= 1'b1;
		offer(8'h01, CIC_LVLN);
		req[1] <= 1'b0;
		gie <= 1'b1;
		for (n = 0; n < 8; n++) begin
			@(negedge clk);
			chk(32'(take), 32'h0);
		end
		st(8'h80);
		ret();
		offer(8'(j), CIC_LVL0);
		req[k] <= 1'b1;
		offer(8'(k), CIC_LVL1);
		req[1] <= 1'b1;
		offer(8'h01, CIC_LVLN);
		req <= 32'h0;
		st(8'h83);
		ret();
		st(8'h03);
		ret();
		st(8'h01);
		ret();
		st(8'h00);
		wb(8'h0c, 1'b1, 8'h00);
		req[k] <= 1'b1;
		offer(8'(k), CIC_LVL0);
		req <= 32'h0;
		ret();
		$display("level test done");
		// Mid-run reset must clear every register again
		setctl(8'h61, 0);
		wb(8'h0c, 1'b1, 8'h07);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		{vsel, compact_table_enable, rr} = 3'h0;
		for (i = 0; i < 4; i++) begin
			wb(8'(i * 4), 1'b0, 8'h00);
			chk(32'(r), 32'h0);
		end
		// Byte lane 0 off: the write is refused
		sel <= 4'h0;
		wb(8'h0c, 1'b1, 8'h05);
		sel <= 4'h1;
		wb(8'h0c, 1'b0, 8'h00);
		chk(32'(r), 32'h0);
		$display("reset test done");
		end_sim();
	end
endmodule
